// ---- hw/ioc_top.sv ----
// Internal oscillator control: enables, ready flags, calibration, source selection
//
// What this block does
// - After reset the system clock runs from the 2 MHz RC source, unconfigured.
// - Any combination of internal oscillators may be enabled together.
// - Ultra-low-power slow oscillator is never a system clock choice.
// - Ultra-low-power oscillator turns on by itself when a consumer needs it.
// - Every reset copies the factory slow RC calibration into its register.
// - Slow RC calibration register is readable and writable by software.
// - Slow RC source is refused as PLL reference.
// - Slow RC feeding the real-time counter is divided to 1.024 kHz.
// - Slow RC may clock system and real-time counter at once.
// - Slow RC is offered as auto-calibration reference for fast oscillators.
// - Slow RC has a control enable bit and a status ready flag.
// - 2 MHz RC has a control enable bit and a status ready flag.
// - 32 MHz ring has a control enable bit and a status ready flag.
// - Reset loads 2/32 MHz calibrations; auto-calibration may adjust them.
// - 2 MHz RC serves as system clock directly or as PLL reference.
// - 32 MHz ring serves as system clock directly or as PLL reference.
// - PLL factor is an integer from 1 to 31.
// - Selecting a not-ready source is refused; current source kept.
// - 32 MHz ring is divided by four before feeding the PLL.
//
// The implementer's own choices: the address-and-strobe port and the address map.
module ioc_top #(
    parameter int SLOW_START_CYC = ioc_pkg::SLOW_START_CYC,
    parameter int MID_START_CYC = ioc_pkg::MID_START_CYC,
    parameter int FAST_START_CYC = ioc_pkg::FAST_START_CYC,
    parameter int PLL_LOCK_CYC = ioc_pkg::PLL_LOCK_CYC
) (
    input wire logic I_MCLK,
    input wire logic I_RST,
    input wire logic [ioc_pkg::AW-1:0] I_ADDR,
    input wire logic [ioc_pkg::DW-1:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [ioc_pkg::DW-1:0] O_RDATA,
    input wire logic [ioc_pkg::DW-1:0] I_SLOW_CAL_ROW,
    input wire logic [ioc_pkg::DW-1:0] I_MID_CAL_ROW,
    input wire logic [ioc_pkg::DW-1:0] I_FAST_CAL_ROW,
    input wire ioc_pkg::ioc_cal_upd_t I_MID_CAL_UPD,
    input wire ioc_pkg::ioc_cal_upd_t I_FAST_CAL_UPD,
    input wire logic I_ULP_REQ,
    input wire logic I_ULP_CLK,
    input wire logic I_SLOW_RC_CLK,
    output logic O_SLOW_RC_EN,
    output logic O_MID_RC_EN,
    output logic O_FAST_RING_EN,
    output logic O_PLL_EN,
    output logic O_ULP_EN,
    output logic [ioc_pkg::SYS_W-1:0] O_SYSCLK_SEL,
    output logic [1:0] O_PLL_SRC,
    output logic [ioc_pkg::PLL_FAC_W-1:0] O_PLL_FACTOR,
    output logic O_PLL_REF_DIV4,
    output logic [ioc_pkg::DW-1:0] O_SLOW_CAL,
    output logic [ioc_pkg::DW-1:0] O_MID_CAL,
    output logic [ioc_pkg::DW-1:0] O_FAST_CAL,
    output logic O_RTC_TICK,
    output logic O_AUTOCAL_REF_OK
);
    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    logic [ioc_pkg::DW-1:0] ctrl_r;
    logic [ioc_pkg::DW-1:0] ctrl_nxt;
    ioc_pkg::ioc_sys_t sys_r;
    ioc_pkg::ioc_sys_t sys_nxt;
    ioc_pkg::ioc_pll_src_t pll_src_r;
    ioc_pkg::ioc_pll_src_t pll_src_nxt;
    logic [ioc_pkg::PLL_FAC_W-1:0] pll_fac_r;
    logic [ioc_pkg::PLL_FAC_W-1:0] pll_fac_nxt;
    logic [ioc_pkg::DW-1:0] slow_cal_r;
    logic [ioc_pkg::DW-1:0] slow_cal_nxt;
    logic [ioc_pkg::DW-1:0] mid_cal_r;
    logic [ioc_pkg::DW-1:0] mid_cal_nxt;
    logic [ioc_pkg::DW-1:0] fast_cal_r;
    logic [ioc_pkg::DW-1:0] fast_cal_nxt;
    logic rtc_slow_r;
    logic rtc_slow_nxt;
    logic load_r;
    logic [ioc_pkg::DW-1:0] rdata_r;
    logic [ioc_pkg::DW-1:0] rdata_nxt;
    logic ulp_en_r;
    logic ulp_en_nxt;
    logic div4_r;
    logic div4_nxt;
    logic refok_r;
    logic refok_nxt;

    logic slow_s1_r;
    logic slow_s2_r;
    logic slow_s3_r;
    logic ulp_s1_r;
    logic ulp_s2_r;
    logic ulp_s3_r;
    logic [ioc_pkg::RTC_CNT_W-1:0] rtc_cnt_r;
    logic [ioc_pkg::RTC_CNT_W-1:0] rtc_cnt_nxt;
    logic rtc_tick_r;
    logic rtc_tick_nxt;

    logic slow_rdy;
    logic mid_rdy;
    logic fast_rdy;
    logic pll_rdy;
    logic wr_ctrl;
    logic wr_sys;
    logic wr_pll;
    logic [ioc_pkg::SYS_W-1:0] sys_req;
    logic [1:0] pll_src_req;
    logic [ioc_pkg::PLL_FAC_W-1:0] pll_fac_req;
    logic [ioc_pkg::DW-1:0] status;
    logic slow_rise;
    logic ulp_rise;

    localparam logic [ioc_pkg::RTC_CNT_W-1:0] RTC_LAST =
        ioc_pkg::RTC_CNT_W'(ioc_pkg::RTC_DIV - 1);

    // ---------------------------------------------------------------
    // Oscillator startup tracking
    // ---------------------------------------------------------------
    ioc_osc_ready #(.CNT_W(ioc_pkg::START_W), .START_CYC(SLOW_START_CYC)) u_slow_rdy (
        .i_clk(I_MCLK),
        .i_rst(I_RST),
        .i_enable(ctrl_r[ioc_pkg::BIT_SLOW]),
        .o_ready(slow_rdy)
    );
    ioc_osc_ready #(.CNT_W(ioc_pkg::START_W), .START_CYC(MID_START_CYC)) u_mid_rdy (
        .i_clk(I_MCLK),
        .i_rst(I_RST),
        .i_enable(ctrl_r[ioc_pkg::BIT_MID]),
        .o_ready(mid_rdy)
    );
    ioc_osc_ready #(.CNT_W(ioc_pkg::START_W), .START_CYC(FAST_START_CYC)) u_fast_rdy (
        .i_clk(I_MCLK),
        .i_rst(I_RST),
        .i_enable(ctrl_r[ioc_pkg::BIT_FAST]),
        .o_ready(fast_rdy)
    );
    ioc_osc_ready #(.CNT_W(ioc_pkg::START_W), .START_CYC(PLL_LOCK_CYC)) u_pll_rdy (
        .i_clk(I_MCLK),
        .i_rst(I_RST),
        .i_enable(ctrl_r[ioc_pkg::BIT_PLL]),
        .o_ready(pll_rdy)
    );

    // ---------------------------------------------------------------
    // Decode
    // ---------------------------------------------------------------
    assign wr_ctrl = I_WR && (I_ADDR == ioc_pkg::OFS_CTRL);
    assign wr_sys = I_WR && (I_ADDR == ioc_pkg::OFS_SYSSEL);
    assign wr_pll = I_WR && (I_ADDR == ioc_pkg::OFS_PLLCFG);
    assign sys_req = I_WDATA[ioc_pkg::SYS_W-1:0];
    assign pll_src_req = I_WDATA[ioc_pkg::PLL_SRC_LSB +: 2];
    assign pll_fac_req = I_WDATA[ioc_pkg::PLL_FAC_LSB +: ioc_pkg::PLL_FAC_W];
    assign slow_rise = slow_s2_r && !slow_s3_r;
    assign ulp_rise = ulp_s2_r && !ulp_s3_r;

    always_comb begin
        status = '0;
        status[ioc_pkg::BIT_SLOW] = slow_rdy;
        status[ioc_pkg::BIT_MID] = mid_rdy;
        status[ioc_pkg::BIT_FAST] = fast_rdy;
        status[ioc_pkg::BIT_PLL] = pll_rdy;
    end

    // ---------------------------------------------------------------
    // Register next state
    // ---------------------------------------------------------------
    always_comb begin
        // Each oscillator enable is independent of the others
        ctrl_nxt = ctrl_r;
        if (wr_ctrl) begin
            ctrl_nxt = I_WDATA & ioc_pkg::CTRL_MASK;
        end
        // The running system clock and its PLL reference cannot be stopped
        case (sys_r)
            ioc_pkg::SYS_MID: ctrl_nxt[ioc_pkg::BIT_MID] = 1'b1;
            ioc_pkg::SYS_SLOW: ctrl_nxt[ioc_pkg::BIT_SLOW] = 1'b1;
            ioc_pkg::SYS_FAST: ctrl_nxt[ioc_pkg::BIT_FAST] = 1'b1;
            ioc_pkg::SYS_PLL: begin
                ctrl_nxt[ioc_pkg::BIT_PLL] = 1'b1;
                if (pll_src_r == ioc_pkg::PLL_FAST_DIV4) begin
                    ctrl_nxt[ioc_pkg::BIT_FAST] = 1'b1;
                end else begin
                    ctrl_nxt[ioc_pkg::BIT_MID] = 1'b1;
                end
            end
            default: ctrl_nxt = ctrl_r;
        endcase

        // Switch only to a stable source; otherwise keep running
        sys_nxt = sys_r;
        if (wr_sys) begin
            case (sys_req)
                ioc_pkg::SYS_MID: if (mid_rdy) sys_nxt = ioc_pkg::SYS_MID;
                ioc_pkg::SYS_SLOW: if (slow_rdy) sys_nxt = ioc_pkg::SYS_SLOW;
                ioc_pkg::SYS_FAST: if (fast_rdy) sys_nxt = ioc_pkg::SYS_FAST;
                ioc_pkg::SYS_PLL: if (pll_rdy) sys_nxt = ioc_pkg::SYS_PLL;
                default: sys_nxt = sys_r;
            endcase
        end

        // PLL setup is frozen while it runs; illegal codes are dropped
        pll_src_nxt = pll_src_r;
        pll_fac_nxt = pll_fac_r;
        if (wr_pll && !ctrl_r[ioc_pkg::BIT_PLL] && pll_fac_req >= ioc_pkg::PLL_FAC_MIN) begin
            if (pll_src_req == ioc_pkg::PLL_MID) begin
                pll_src_nxt = ioc_pkg::PLL_MID;
                pll_fac_nxt = pll_fac_req;
            end else if (pll_src_req == ioc_pkg::PLL_FAST_DIV4) begin
                pll_src_nxt = ioc_pkg::PLL_FAST_DIV4;
                pll_fac_nxt = pll_fac_req;
            end
        end
        div4_nxt = (pll_src_nxt == ioc_pkg::PLL_FAST_DIV4);

        // Factory load in the first cycle after reset beats any other update
        slow_cal_nxt = slow_cal_r;
        mid_cal_nxt = mid_cal_r;
        fast_cal_nxt = fast_cal_r;
        if (load_r) begin
            slow_cal_nxt = I_SLOW_CAL_ROW;
            mid_cal_nxt = I_MID_CAL_ROW;
            fast_cal_nxt = I_FAST_CAL_ROW;
        end else begin
            if (I_WR && I_ADDR == ioc_pkg::OFS_SLOWCAL) begin
                slow_cal_nxt = I_WDATA;
            end
            if (I_MID_CAL_UPD.valid) begin
                mid_cal_nxt = I_MID_CAL_UPD.value;
            end
            if (I_FAST_CAL_UPD.valid) begin
                fast_cal_nxt = I_FAST_CAL_UPD.value;
            end
        end

        rtc_slow_nxt = rtc_slow_r;
        if (I_WR && I_ADDR == ioc_pkg::OFS_RTCSEL) begin
            rtc_slow_nxt = I_WDATA[ioc_pkg::RTC_SEL_BIT];
        end

        // No software bit: demand, or the real-time counter running from it, wakes the low-power oscillator
        ulp_en_nxt = I_ULP_REQ || !rtc_slow_r;
        refok_nxt = slow_rdy;

        rdata_nxt = ioc_pkg::UNMAPPED_RD;
        if (I_RD) begin
            case (I_ADDR)
                ioc_pkg::OFS_CTRL: rdata_nxt = ctrl_r;
                ioc_pkg::OFS_STATUS: rdata_nxt = status;
                ioc_pkg::OFS_SYSSEL: rdata_nxt = {5'h00, sys_r};
                ioc_pkg::OFS_PLLCFG: rdata_nxt = {1'b0, pll_src_r, pll_fac_r};
                ioc_pkg::OFS_SLOWCAL: rdata_nxt = slow_cal_r;
                ioc_pkg::OFS_MIDCAL: rdata_nxt = mid_cal_r;
                ioc_pkg::OFS_FASTCAL: rdata_nxt = fast_cal_r;
                ioc_pkg::OFS_RTCSEL: rdata_nxt = {7'h00, rtc_slow_r};
                default: rdata_nxt = ioc_pkg::UNMAPPED_RD;
            endcase
        end
    end

    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            ctrl_r <= ioc_pkg::CTRL_RST;
            sys_r <= ioc_pkg::SYS_MID;
            pll_src_r <= ioc_pkg::PLL_MID;
            pll_fac_r <= ioc_pkg::PLL_FAC_RST;
            div4_r <= 1'b0;
            slow_cal_r <= ioc_pkg::CAL_RST;
            mid_cal_r <= ioc_pkg::CAL_RST;
            fast_cal_r <= ioc_pkg::CAL_RST;
            rtc_slow_r <= 1'b0;
            load_r <= 1'b1;
            ulp_en_r <= 1'b1;
            refok_r <= 1'b0;
            rdata_r <= ioc_pkg::UNMAPPED_RD;
        end else begin
            ctrl_r <= ctrl_nxt;
            sys_r <= sys_nxt;
            pll_src_r <= pll_src_nxt;
            pll_fac_r <= pll_fac_nxt;
            div4_r <= div4_nxt;
            slow_cal_r <= slow_cal_nxt;
            mid_cal_r <= mid_cal_nxt;
            fast_cal_r <= fast_cal_nxt;
            rtc_slow_r <= rtc_slow_nxt;
            load_r <= 1'b0;
            ulp_en_r <= ulp_en_nxt;
            refok_r <= refok_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Real-time counter tick
    // ---------------------------------------------------------------
    // Slow clocks are sampled, so the core clock must far outrun them
    always_comb begin
        rtc_cnt_nxt = rtc_cnt_r;
        rtc_tick_nxt = 1'b0;
        if (rtc_slow_r) begin
            if (slow_rise && slow_rdy) begin
                if (rtc_cnt_r == RTC_LAST) begin
                    rtc_cnt_nxt = '0;
                    rtc_tick_nxt = 1'b1;
                end else begin
                    rtc_cnt_nxt = rtc_cnt_r + 1'b1;
                end
            end
        end else begin
            rtc_cnt_nxt = '0;
            rtc_tick_nxt = ulp_rise;
        end
    end

    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            slow_s1_r <= 1'b0;
            slow_s2_r <= 1'b0;
            slow_s3_r <= 1'b0;
            ulp_s1_r <= 1'b0;
            ulp_s2_r <= 1'b0;
            ulp_s3_r <= 1'b0;
            rtc_cnt_r <= '0;
            rtc_tick_r <= 1'b0;
        end else begin
            slow_s1_r <= I_SLOW_RC_CLK;
            slow_s2_r <= slow_s1_r;
            slow_s3_r <= slow_s2_r;
            ulp_s1_r <= I_ULP_CLK;
            ulp_s2_r <= ulp_s1_r;
            ulp_s3_r <= ulp_s2_r;
            rtc_cnt_r <= rtc_cnt_nxt;
            rtc_tick_r <= rtc_tick_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign O_RDATA = rdata_r;
    assign O_SLOW_RC_EN = ctrl_r[ioc_pkg::BIT_SLOW];
    assign O_MID_RC_EN = ctrl_r[ioc_pkg::BIT_MID];
    assign O_FAST_RING_EN = ctrl_r[ioc_pkg::BIT_FAST];
    assign O_PLL_EN = ctrl_r[ioc_pkg::BIT_PLL];
    assign O_ULP_EN = ulp_en_r;
    assign O_SYSCLK_SEL = sys_r;
    assign O_PLL_SRC = pll_src_r;
    assign O_PLL_FACTOR = pll_fac_r;
    assign O_PLL_REF_DIV4 = div4_r;
    assign O_SLOW_CAL = slow_cal_r;
    assign O_MID_CAL = mid_cal_r;
    assign O_FAST_CAL = fast_cal_r;
    assign O_RTC_TICK = rtc_tick_r;
    assign O_AUTOCAL_REF_OK = refok_r;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (I_RST);

    sys_change_a: assert property (
        $changed(sys_r) |-> $past(wr_sys))
        else $error("System source changed without a select write");
    sys_ready_a: assert property (
        (sys_r == ioc_pkg::SYS_FAST) |-> fast_rdy)
        else $error("Fast ring selected while not ready");
    sys_legal_a: assert property (
        sys_r inside {ioc_pkg::SYS_MID, ioc_pkg::SYS_SLOW, ioc_pkg::SYS_FAST,
                      ioc_pkg::SYS_PLL})
        else $error("Illegal system source code");
    ulp_auto_a: assert property (
        I_ULP_REQ |=> O_ULP_EN)
        else $error("Low-power oscillator not woken on demand");
    cal_load_a: assert property (
        load_r |=> (O_SLOW_CAL == $past(I_SLOW_CAL_ROW)) && (O_MID_CAL == $past(I_MID_CAL_ROW)))
        else $error("Factory calibration not loaded");
    cal_write_a: assert property (
        (I_WR && I_ADDR == ioc_pkg::OFS_SLOWCAL && !load_r) |=> O_SLOW_CAL == $past(I_WDATA))
        else $error("Slow calibration write lost");
    cal_upd_a: assert property (
        (I_FAST_CAL_UPD.valid && !load_r) |=> O_FAST_CAL == $past(I_FAST_CAL_UPD.value))
        else $error("Fast calibration update lost");
    pll_src_a: assert property (
        pll_src_r inside {ioc_pkg::PLL_MID, ioc_pkg::PLL_FAST_DIV4})
        else $error("Illegal PLL reference");
    pll_fac_a: assert property (
        (wr_pll && pll_fac_req == 5'h00) |=> $stable(pll_fac_r))
        else $error("Zero PLL factor accepted");
    rtc_div_a: assert property (
        (rtc_tick_nxt && rtc_slow_r) |-> (rtc_cnt_r == RTC_LAST) && slow_rise)
        else $error("Real-time tick off the divide ratio");
    div4_a: assert property (
        (pll_src_r == ioc_pkg::PLL_FAST_DIV4) |-> ##0 O_PLL_REF_DIV4)
        else $error("Fast ring reaches PLL undivided");
    keep_sys_a: assert property (
        (sys_r == ioc_pkg::SYS_MID) |-> O_MID_RC_EN && $past(O_MID_RC_EN))
        else $error("Running system oscillator disabled");
    ready_drop_a: assert property (
        !O_SLOW_RC_EN |=> !slow_rdy)
        else $error("Ready flag survives disable");
    mid_ready_a: assert property (
        $rose(mid_rdy) |-> O_MID_RC_EN && $past(O_MID_RC_EN, 2))
        else $error("Mid ready without prior enable");
    refok_a: assert property (
        slow_rdy |=> O_AUTOCAL_REF_OK)
        else $error("Calibration reference not offered");
endmodule

// ---- hw/ioc_pkg.sv ----
// Package of constants and types for the internal oscillator control block
package ioc_pkg;
    // ---------------------------------------------------------------
    // Bus geometry
    // ---------------------------------------------------------------
    localparam int DW = 8;
    localparam int AW = 4;

    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [AW-1:0] OFS_CTRL = 4'h0;
    localparam logic [AW-1:0] OFS_STATUS = 4'h1;
    localparam logic [AW-1:0] OFS_SYSSEL = 4'h2;
    localparam logic [AW-1:0] OFS_PLLCFG = 4'h3;
    localparam logic [AW-1:0] OFS_SLOWCAL = 4'h4;
    localparam logic [AW-1:0] OFS_MIDCAL = 4'h5;
    localparam logic [AW-1:0] OFS_FASTCAL = 4'h6;
    localparam logic [AW-1:0] OFS_RTCSEL = 4'h7;

    // ---------------------------------------------------------------
    // Field positions; the oscillator bits are shared by control and status
    // ---------------------------------------------------------------
    localparam int BIT_SLOW = 0;
    localparam int BIT_MID = 1;
    localparam int BIT_FAST = 2;
    localparam int BIT_PLL = 4;
    localparam logic [DW-1:0] CTRL_MASK = 8'h17;
    localparam int PLL_FAC_LSB = 0;
    localparam int PLL_FAC_W = 5;
    localparam int PLL_SRC_LSB = 5;
    localparam int SYS_W = 3;
    localparam int RTC_SEL_BIT = 0;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [DW-1:0] CTRL_RST = 8'h02;
    localparam logic [PLL_FAC_W-1:0] PLL_FAC_RST = 5'h01;
    localparam logic [PLL_FAC_W-1:0] PLL_FAC_MIN = 5'h01;
    localparam logic [DW-1:0] CAL_RST = 8'h00;
    localparam logic [DW-1:0] UNMAPPED_RD = 8'h00;

    // ---------------------------------------------------------------
    // Modes
    // ---------------------------------------------------------------
    typedef enum logic [SYS_W-1:0] {
        SYS_MID = 3'b000,
        SYS_SLOW = 3'b001,
        SYS_FAST = 3'b010,
        SYS_PLL = 3'b011
    } ioc_sys_t;

    typedef enum logic [1:0] {
        PLL_MID = 2'b00,
        PLL_FAST_DIV4 = 2'b01
    } ioc_pll_src_t;

    typedef struct packed {
        logic valid;
        logic [DW-1:0] value;
    } ioc_cal_upd_t;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int SLOW_RC_HZ = 32768;
    localparam int RTC_HZ = 1024;
    localparam int RTC_DIV = SLOW_RC_HZ / RTC_HZ;
    localparam int RTC_CNT_W = 5;
    localparam int START_W = 12;
    localparam int SLOW_START_CYC = 1024;
    localparam int MID_START_CYC = 256;
    localparam int FAST_START_CYC = 512;
    localparam int PLL_LOCK_CYC = 64;
endpackage

// ---- hw/ioc_osc_ready.sv ----
// Startup counter giving one oscillator's ready flag
module ioc_osc_ready #(
    parameter int CNT_W = 12,
    parameter int START_CYC = 256
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_enable,
    output logic o_ready
);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(START_CYC - 1);

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic ready_r;
    logic ready_nxt;

    // Dropping the enable loses stability at once
    always_comb begin
        cnt_nxt = cnt_r;
        ready_nxt = ready_r;
        if (!i_enable) begin
            cnt_nxt = '0;
            ready_nxt = 1'b0;
        end else if (cnt_r == LAST) begin
            ready_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_r <= '0;
            ready_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            ready_r <= ready_nxt;
        end
    end

    assign o_ready = ready_r;
endmodule

// ---- test/tb.sv ----
// Self-checking bench for the internal oscillator control block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, wr, rd, ulp_req, ulp_clk, slow_clk;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, slow_row, mid_row, fast_row, v;
    ioc_pkg::ioc_cal_upd_t mid_upd, fast_upd;
    logic slow_en, mid_en, fast_en, pll_en, ulp_en, div4, tick, ref_ok;
    logic [2:0] sys_sel;
    logic [1:0] pll_src;
    logic [4:0] pll_fac;
    logic [7:0] slow_cal, mid_cal, fast_cal;
    int error_cnt, checks_done, slow_edges, ulp_ticks;
    int tick_at[$];
    int mdl[16];

    ioc_top #(.SLOW_START_CYC(4), .MID_START_CYC(4), .FAST_START_CYC(4), .PLL_LOCK_CYC(4)) i_ioc_top (
        .I_MCLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
        .O_RDATA(rdata), .I_SLOW_CAL_ROW(slow_row), .I_MID_CAL_ROW(mid_row),
        .I_FAST_CAL_ROW(fast_row), .I_MID_CAL_UPD(mid_upd), .I_FAST_CAL_UPD(fast_upd),
        .I_ULP_REQ(ulp_req), .I_ULP_CLK(ulp_clk), .I_SLOW_RC_CLK(slow_clk),
        .O_SLOW_RC_EN(slow_en), .O_MID_RC_EN(mid_en), .O_FAST_RING_EN(fast_en),
        .O_PLL_EN(pll_en), .O_ULP_EN(ulp_en), .O_SYSCLK_SEL(sys_sel), .O_PLL_SRC(pll_src),
        .O_PLL_FACTOR(pll_fac), .O_PLL_REF_DIV4(div4), .O_SLOW_CAL(slow_cal),
        .O_MID_CAL(mid_cal), .O_FAST_CAL(fast_cal), .O_RTC_TICK(tick),
        .O_AUTOCAL_REF_OK(ref_ok));

    // ---------------------------------------------------------------
    // Clock, tick recorder and watchdog
    // ---------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (tick === 1'b1) begin
            tick_at.push_back(slow_edges);
            ulp_ticks++;
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        tally_and_finish();
    end

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string name);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Reads back and compares against the register model
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rdata, 8'(mdl[a]), "rdata");
    endtask

    // Pin pulses slow enough for the two-flop synchroniser
    task automatic pulses(input bit slow, input int n);
        repeat (n) begin
            @(posedge clk);
            if (slow) slow_clk <= 1'b1;
            else ulp_clk <= 1'b1;
            slow_edges++;
            repeat (3) @(posedge clk);
            slow_clk <= 1'b0;
            ulp_clk <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask

    task automatic tally_and_finish();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        void'($urandom(32'h31f0));
        {rst, wr, rd, addr, wdata, ulp_req, ulp_clk, slow_clk} = '0;
        rst = 1'b1;
        slow_row = 8'($urandom);
        mid_row = 8'($urandom);
        fast_row = 8'($urandom);
        mid_upd = '0;
        fast_upd = '0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        mdl = '{default: 0};
        mdl[0] = 2;
        mdl[3] = 1;
        mdl[4] = slow_row;
        mdl[5] = mid_row;
        mdl[6] = fast_row;
        check(8'(sys_sel), 8'h00, "sysclk_sel");
        check(8'(ulp_en), 8'h01, "ulp_en");
        check(slow_cal, slow_row, "slow_cal");
        for (int a = 0; a < 16; a++) if (a != 1) rd_reg(a[3:0]);
        wr_reg(ioc_pkg::OFS_SYSSEL, 8'h01);
        rd_reg(ioc_pkg::OFS_SYSSEL);
        wr_reg(ioc_pkg::OFS_CTRL, 8'h07);
        mdl[0] = 7;
        mdl[1] = 7;
        repeat (20) @(posedge clk);
        rd_reg(ioc_pkg::OFS_CTRL);
        rd_reg(ioc_pkg::OFS_STATUS);
        check(8'(ref_ok), 8'h01, "autocal_ref");
        for (int c = 4; c < 8; c++) wr_reg(ioc_pkg::OFS_SYSSEL, 8'(c));
        rd_reg(ioc_pkg::OFS_SYSSEL);
        wr_reg(ioc_pkg::OFS_SYSSEL, 8'h01);
        mdl[2] = 1;
        rd_reg(ioc_pkg::OFS_SYSSEL);
        wr_reg(ioc_pkg::OFS_CTRL, 8'h02);
        mdl[0] = 3;
        mdl[1] = 3;
        repeat (2) @(posedge clk);
        rd_reg(ioc_pkg::OFS_CTRL);
        rd_reg(ioc_pkg::OFS_STATUS);
        v = 8'($urandom);
        wr_reg(ioc_pkg::OFS_SLOWCAL, v);
        mdl[4] = v;
        rd_reg(ioc_pkg::OFS_SLOWCAL);
        check(slow_cal, v, "slow_cal");
        wr_reg(ioc_pkg::OFS_MIDCAL, ~mid_row);
        rd_reg(ioc_pkg::OFS_MIDCAL);
        @(posedge clk);
        mid_upd <= '{valid: 1'b1, value: v};
        fast_upd <= '{valid: 1'b1, value: ~v};
        @(posedge clk);
        mid_upd.valid <= 1'b0;
        fast_upd.valid <= 1'b0;
        @(posedge clk);
        #1;
        check(mid_cal, v, "mid_cal");
        check(fast_cal, ~v, "fast_cal");
        wr_reg(ioc_pkg::OFS_PLLCFG, 8'h00);
        wr_reg(ioc_pkg::OFS_PLLCFG, 8'h5f);
        rd_reg(ioc_pkg::OFS_PLLCFG);
        wr_reg(ioc_pkg::OFS_PLLCFG, 8'h3f);
        mdl[3] = 8'h3f;
        rd_reg(ioc_pkg::OFS_PLLCFG);
        check(8'(pll_fac), 8'h1f, "pll_factor");
        check(8'(div4), 8'h01, "pll_div4");
        wr_reg(ioc_pkg::OFS_PLLCFG, 8'h01);
        mdl[3] = 1;
        rd_reg(ioc_pkg::OFS_PLLCFG);
        check(8'(pll_src), 8'h00, "pll_src");
        ulp_ticks = 0;
        pulses(1'b0, 4);
        repeat (6) @(posedge clk);
        check(8'(ulp_ticks), 8'h04, "ulp_ticks");
        wr_reg(ioc_pkg::OFS_RTCSEL, 8'h01);
        repeat (2) @(posedge clk);
        check(8'(ulp_en), 8'h00, "ulp_en");
        ulp_req <= 1'b1;
        repeat (2) @(posedge clk);
        check(8'(ulp_en), 8'h01, "ulp_en");
        ulp_req <= 1'b0;
        tick_at.delete();
        pulses(1'b1, 70);
        check(8'(tick_at.size() >= 2), 8'h01, "rtc_ticks");
        if (tick_at.size() >= 2) check(8'(tick_at[1] - tick_at[0]), 8'h20, "rtc_div");
        // Fast ring as system clock, then the PLL fed from the mid RC
        wr_reg(ioc_pkg::OFS_CTRL, 8'h07);
        repeat (8) @(posedge clk);
        wr_reg(ioc_pkg::OFS_SYSSEL, 8'h02);
        mdl[2] = 2;
        rd_reg(ioc_pkg::OFS_SYSSEL);
        wr_reg(ioc_pkg::OFS_CTRL, 8'h12);
        mdl[0] = 8'h16;
        repeat (8) @(posedge clk);
        rd_reg(ioc_pkg::OFS_CTRL);
        check(8'({pll_en, fast_en, mid_en, slow_en}), 8'h0e, "osc_en");
        wr_reg(ioc_pkg::OFS_PLLCFG, 8'h3f);
        rd_reg(ioc_pkg::OFS_PLLCFG);
        wr_reg(ioc_pkg::OFS_SYSSEL, 8'h03);
        mdl[2] = 3;
        rd_reg(ioc_pkg::OFS_SYSSEL);
        wr_reg(ioc_pkg::OFS_CTRL, 8'h00);
        mdl[0] = 8'h12;
        mdl[1] = 8'h12;
        rd_reg(ioc_pkg::OFS_CTRL);
        rd_reg(ioc_pkg::OFS_STATUS);
        // Second reset in mid-run reloads a fresh factory value
        @(posedge clk);
        slow_row <= 8'($urandom);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check(slow_cal, slow_row, "slow_cal");
        check(8'(sys_sel), 8'h00, "sysclk_sel");
        tally_and_finish();
    end
endmodule
